// File: common/ubrg_pkg.sv
/*
  Constants shared by the baud-rate generator core and its testbench:
  register offsets, field positions, reset values, encodings and counts.
  Assumes a 32-bit classic Wishbone register bus with byte addressing.
*/
package ubrg_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_BAUD = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // reset values
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] BAUD_RESET = 16'h0000;
  localparam logic [15:0] MODE_MASK = 16'h1FFF;

  ////////////////////////////////////////////////////////////////////////////
  // port_mode_reg field positions
  localparam int MODE_SRC_LSB = 0;
  localparam int MODE_SYNC_BIT = 2;
  localparam int MODE_OVER_BIT = 3;
  localparam int MODE_CHRL_LSB = 4;
  localparam int MODE_NINE_BIT = 6;
  localparam int MODE_MSBF_BIT = 7;
  localparam int MODE_PAR_LSB = 8;
  localparam int MODE_STOP_LSB = 11;

  // status register field positions
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_STALL_BIT = 1;
  localparam int STAT_FLEN_LSB = 4;
  localparam int STAT_HALF_LSB = 8;

  ////////////////////////////////////////////////////////////////////////////
  // clock_source_select codes; the unused code behaves as the master clock
  localparam logic [1:0] SRC_MASTER = 2'h0;
  localparam logic [1:0] SRC_DIV = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h3;

  // stop length codes; the unused code behaves as one stop bit
  localparam logic [1:0] STOP_ONE = 2'h0;
  localparam logic [1:0] STOP_ONEHALF = 2'h1;
  localparam logic [1:0] STOP_TWO = 2'h2;

  // parity codes: below PAR_NONE a parity slot exists
  localparam logic [2:0] PAR_EVEN = 3'h0;
  localparam logic [2:0] PAR_ODD = 3'h1;
  localparam logic [2:0] PAR_SPACE = 3'h2;
  localparam logic [2:0] PAR_MARK = 3'h3;
  localparam logic [2:0] PAR_NONE = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // counts
  localparam int BAUD_DIV_WIDTH = 16;
  localparam int PRESCALE_DIV = 8;
  localparam logic [3:0] OS16_LAST = 4'hF;
  localparam logic [3:0] OS8_LAST = 4'h7;
  localparam logic [3:0] MIN_DATA_BITS = 4'h5;
  localparam logic [3:0] NINE_DATA_BITS = 4'h9;
  localparam int SLOT_WIDTH = 8;
endpackage

// File: core/ubrg_slot_buf.sv
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock and a synchronous active-low reset; outputs are flops.
*/
`timescale 1ns/10ps
module ubrg_slot_buf #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] spare;
  logic spare_valid;

  // push only while the spare entry is free, pop from the head
  wire push = in_valid & ~spare_valid;
  wire pop = out_valid & out_ready;

  ////////////////////////////////////////////////////////////////////////////
  // head entry drives the outputs directly so nothing leaves combinationally
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      spare_valid <= 1'b0;
      out_data <= '0;
      spare <= '0;
    end else begin
      unique case ({push, pop})
        2'b10: begin
          if (!out_valid) begin
            out_data <= in_data;
            out_valid <= 1'b1;
          end else begin
            spare <= in_data;
            spare_valid <= 1'b1;
          end
        end
        2'b01: begin
          out_data <= spare;
          out_valid <= spare_valid;
          spare_valid <= 1'b0;
        end
        2'b11: out_data <= in_data; // spare is empty whenever push is allowed
        2'b00: out_valid <= out_valid;
      endcase
    end
  end

  // ready reflects the spare entry, a registered state
  assign in_ready = ~spare_valid;
endmodule

// File: core/ubrg_top.sv
/*
  Baud-rate generator and frame envelope of a serial port, with its
  Wishbone register slave and a two-entry slot buffer toward the consumer.
  Assumes inputs synchronous to ref_clk and a gated functional clock
  presented as the clk_en level.
*/
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
// What this block does
// - one bit clock is made and that same tick feeds both receiver and transmitter.
// - the divider input is the master clock, the master clock over eight, or the serial clock pin.
// - the selected source is divided by a 16-bit divider set from the baud divisor.
// - a baud divisor of zero stops all baud ticks, except the pin clock passed through in synchronous mode.
// - a baud divisor of one passes the selected source through undivided.
// - in asynchronous mode the divided clock is the sampling tick, further divided by 16 or 8.
// - in asynchronous mode with the oversample bit set sampling runs at eight times the bit rate, else sixteen.
// - when the functional clock stops, all counters hold and resume where they left off.
// - register writes are taken even while the functional clock is stopped.
// - asynchronous frames allow 5 to 9 data bits, either order, 1, 1.5 or 2 stops, any parity.
// - synchronous frames allow the same except that only 1 or 2 stop bits exist.
// - in synchronous mode the bit clock is source over divisor, or the pin clock as is.
module ubrg_top #(
  parameter int DIV_WIDTH = ubrg_pkg::BAUD_DIV_WIDTH,
  parameter int PRESCALE = ubrg_pkg::PRESCALE_DIV,
  parameter int SLOT_W = ubrg_pkg::SLOT_WIDTH
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic sck_in,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  output logic sample_tick,
  output logic bit_tick,
  output logic slot_valid,
  input wire logic slot_ready,
  output logic [SLOT_W-1:0] slot_data
);
  localparam int PW = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
  localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);

  logic [15:0] port_mode_reg;
  logic [DIV_WIDTH-1:0] baud_gen_reg;
  logic [PW-1:0] pre_cnt;
  logic [DIV_WIDTH-1:0] div_cnt;
  logic [3:0] os_cnt;
  logic [3:0] pos;
  logic sck_q;
  logic buf_ready;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_req = bus_req & wb_we_i;
  wire wr_mode = wr_req & (wb_adr_i == ubrg_pkg::ADDR_MODE);
  wire wr_baud = wr_req & (wb_adr_i == ubrg_pkg::ADDR_BAUD);
  wire [15:0] next_mode = {wb_sel_i[1] ? wb_dat_i[15:8] : port_mode_reg[15:8],
                           wb_sel_i[0] ? wb_dat_i[7:0] : port_mode_reg[7:0]};
  wire [15:0] baud_ext = 16'(baud_gen_reg);
  wire [15:0] next_baud = {wb_sel_i[1] ? wb_dat_i[15:8] : baud_ext[15:8],
                           wb_sel_i[0] ? wb_dat_i[7:0] : baud_ext[7:0]};

  // mode fields
  wire [1:0] clock_source_select = port_mode_reg[ubrg_pkg::MODE_SRC_LSB +: 2];
  wire mode_sync = port_mode_reg[ubrg_pkg::MODE_SYNC_BIT];
  wire mode_over = port_mode_reg[ubrg_pkg::MODE_OVER_BIT];
  wire [1:0] chrl = port_mode_reg[ubrg_pkg::MODE_CHRL_LSB +: 2];
  wire nine_bits = port_mode_reg[ubrg_pkg::MODE_NINE_BIT];
  wire msbf = port_mode_reg[ubrg_pkg::MODE_MSBF_BIT];
  wire [2:0] par_sel = port_mode_reg[ubrg_pkg::MODE_PAR_LSB +: 3];
  wire [1:0] stop_sel = port_mode_reg[ubrg_pkg::MODE_STOP_LSB +: 2];
  wire [DIV_WIDTH-1:0] baud_divisor = baud_gen_reg;

  ////////////////////////////////////////////////////////////////////////////
  // source selection; the pin edge is a plain sample since inputs are synchronous
  wire pre_wrap = clk_en & (pre_cnt == PRE_LAST);
  wire ext_rise = sck_in & ~sck_q;
  wire src_is_div = clock_source_select == ubrg_pkg::SRC_DIV;
  wire src_is_ext = clock_source_select == ubrg_pkg::SRC_EXT;
  wire src_tick = src_is_ext ? ext_rise : (src_is_div ? pre_wrap : 1'b1);
  // a full slot buffer or a stopped functional clock freezes the generator
  wire go = clk_en & buf_ready;
  wire adv = go & src_tick;

  // divider
  wire cd_zero = baud_divisor == '0;
  wire cd_one = baud_divisor == DIV_WIDTH'(1);
  wire div_wrap = div_cnt == (baud_divisor - DIV_WIDTH'(1));
  wire div_tick = adv & ~cd_zero & (cd_one | div_wrap);
  wire ext_sync = mode_sync & src_is_ext;

  // oversampling stage and tick selection
  wire [3:0] os_last = mode_over ? ubrg_pkg::OS8_LAST : ubrg_pkg::OS16_LAST;
  wire async_bit = div_tick & (os_cnt == os_last);
  wire sync_bit = ext_sync ? adv : div_tick;
  wire next_sample = mode_sync ? sync_bit : div_tick;
  wire next_bit = mode_sync ? sync_bit : async_bit;

  ////////////////////////////////////////////////////////////////////////////
  // frame envelope; fractional stop only exists in asynchronous mode
  wire [3:0] data_bits = nine_bits ? ubrg_pkg::NINE_DATA_BITS
                                   : ubrg_pkg::MIN_DATA_BITS + {2'b00, chrl};
  wire par_en = par_sel < ubrg_pkg::PAR_NONE;
  wire half_stop = (stop_sel == ubrg_pkg::STOP_ONEHALF) & ~mode_sync;
  wire two_stop = stop_sel == ubrg_pkg::STOP_TWO;
  wire [3:0] core_bits = 4'h1 + data_bits + {3'b000, par_en};
  wire [3:0] frame_ticks = core_bits + ((two_stop | half_stop) ? 4'h2 : 4'h1);
  wire [4:0] stop_half = two_stop ? 5'h04 : (half_stop ? 5'h03 : 5'h02);
  wire [4:0] frame_half = {core_bits, 1'b0} + stop_half;
  wire last_slot = pos >= (frame_ticks - 4'h1);
  wire par_slot = par_en & (pos == (data_bits + 4'h1));
  wire [7:0] slot_word = {msbf, par_slot, last_slot, pos == 4'h0, pos};

  // register read mux
  wire [31:0] status_word = {19'h0, frame_half, frame_ticks, 2'b00, ~buf_ready,
                             ~cd_zero | ext_sync};
  wire [31:0] rd_word = (wb_adr_i == ubrg_pkg::ADDR_MODE) ? {16'h0, port_mode_reg} :
                        (wb_adr_i == ubrg_pkg::ADDR_BAUD) ? {16'h0, baud_ext} :
                        (wb_adr_i == ubrg_pkg::ADDR_STATUS) ? status_word : 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave; registers ignore clk_en so setup works with the clock gated
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      port_mode_reg <= ubrg_pkg::MODE_RESET;
      baud_gen_reg <= DIV_WIDTH'(ubrg_pkg::BAUD_RESET);
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_word : 32'h0;
      if (wr_mode) port_mode_reg <= next_mode & ubrg_pkg::MODE_MASK;
      if (wr_baud) baud_gen_reg <= DIV_WIDTH'(next_baud);
    end
  end

  // prescaler and pin edge follow the functional clock only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pre_cnt <= '0;
      sck_q <= 1'b0;
    end else if (clk_en) begin
      pre_cnt <= pre_wrap ? '0 : pre_cnt + PW'(1);
      sck_q <= sck_in;
    end
  end

  // divider and oversample counters; a divisor write restarts both
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      div_cnt <= '0;
      os_cnt <= 4'h0;
    end else if (wr_baud) begin
      div_cnt <= '0;
      os_cnt <= 4'h0;
    end else begin
      if (adv & ~cd_zero) div_cnt <= div_wrap ? '0 : div_cnt + DIV_WIDTH'(1);
      if (div_tick & ~mode_sync) os_cnt <= (os_cnt == os_last) ? 4'h0 : os_cnt + 4'h1;
    end
  end

  // tick outputs and frame position; a mode write restarts the frame
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sample_tick <= 1'b0;
      bit_tick <= 1'b0;
      pos <= 4'h0;
    end else begin
      sample_tick <= next_sample;
      bit_tick <= next_bit;
      if (wr_mode) pos <= 4'h0;
      else if (next_bit) pos <= last_slot ? 4'h0 : pos + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slot stream: one word per bit tick, back-pressure stalls the generator
  ubrg_slot_buf #(.WIDTH(SLOT_W)) u_slot_buf (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(next_bit),
    .in_ready(buf_ready),
    .in_data(SLOT_W'(slot_word)),
    .out_valid(slot_valid),
    .out_ready(slot_ready),
    .out_data(slot_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // helper state read only by the checks below
  logic [DIV_WIDTH-1:0] adv_since;
  logic [4:0] samp_since;
  logic cfg_clean;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      adv_since <= '0;
      samp_since <= 5'h00;
      cfg_clean <= 1'b0;
    end else begin
      adv_since <= (wr_baud | div_tick) ? '0 : adv_since + DIV_WIDTH'(adv);
      samp_since <= bit_tick ? 5'h00 : samp_since + {4'h0, sample_tick};
      cfg_clean <= (wr_mode | wr_baud) ? 1'b0 : (bit_tick ? 1'b1 : cfg_clean);
    end
  end

  default clocking ck @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_reload_two;
    wr_baud && wb_sel_i[1:0] == 2'b11 && wb_dat_i[15:0] == 16'h0002;
  endsequence
  sequence s_two_steps;
    (adv && !wr_baud)[*2];
  endsequence

  property p_zero_silent;
    (cd_zero && !ext_sync) |=> !sample_tick && !bit_tick;
  endproperty
  a_zero_silent: assert property (p_zero_silent) else $error("tick with zero divisor");

  property p_bypass;
    (cd_one && adv) |=> sample_tick;
  endproperty
  a_bypass: assert property (p_bypass) else $error("divisor one did not bypass");

  property p_div_ratio;
    div_tick |-> adv_since == baud_divisor - DIV_WIDTH'(1);
  endproperty
  a_div_ratio: assert property (p_div_ratio) else $error("divider ratio wrong");

  property p_os16;
    (bit_tick && cfg_clean && !mode_sync && !mode_over) |-> samp_since == 5'd15;
  endproperty
  a_os16: assert property (p_os16) else $error("not 16 samples per bit");

  property p_os8;
    (bit_tick && cfg_clean && !mode_sync && mode_over) |-> samp_since == 5'd7;
  endproperty
  a_os8: assert property (p_os8) else $error("not 8 samples per bit");

  property p_reload;
    s_reload_two ##1 s_two_steps |-> div_tick;
  endproperty
  a_reload: assert property (p_reload) else $error("reload not honoured");

  property p_hold;
    (!clk_en && !wr_baud && !wr_mode) |=>
      $stable(div_cnt) && $stable(os_cnt) && $stable(pos) && !bit_tick && !sample_tick;
  endproperty
  a_hold: assert property (p_hold) else $error("state moved while gated");

  property p_gated_write;
    (!clk_en && wr_baud && wb_sel_i[1:0] == 2'b11) |=>
      baud_ext == $past(wb_dat_i[15:0]);
  endproperty
  a_gated_write: assert property (p_gated_write) else $error("gated write lost");

  property p_prescale;
    (src_is_div && src_tick) |=> (!src_tick || !src_is_div)[*7];
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescaler too fast");

  property p_ext_sync;
    (ext_sync && adv) |=> bit_tick && sample_tick;
  endproperty
  a_ext_sync: assert property (p_ext_sync) else $error("pin clock not passed");

  property p_no_frac_sync;
    mode_sync |-> !frame_half[0];
  endproperty
  a_no_frac_sync: assert property (p_no_frac_sync) else $error("half stop in sync");

  property p_frac_async;
    (!mode_sync && stop_sel == ubrg_pkg::STOP_ONEHALF) |-> frame_half[0];
  endproperty
  a_frac_async: assert property (p_frac_async) else $error("half stop missing");
endmodule

// File: tb/ubrg_far_end.sv
/*
  Far-end serial device model: drives the serial clock pin.
  Assumes the bench raises run only while it wants pin clock edges.
*/
`timescale 1ns/10ps
module ubrg_far_end #(
  parameter int HALF = 5
) (
  input wire logic ref_clk,
  input wire logic run,
  output logic sck = 1'b0
);
  int cnt = 0;

  ////////////////////////////////////////////////////////////////////////////
  // pin clock, low and still outside frames; each level holds HALF cycles
  always @(posedge ref_clk) begin
    if (!run) begin
      cnt <= 0;
      sck <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      sck <= ~sck;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// File: tb/test_usart_baud_rate_generator.sv
/*
  Self-checking bench for the baud generator: register bus, tick spacing,
  clock gating and the slot stream. Assumes the far-end model drives sck_in.
*/
`timescale 1ns/10ps
module test_usart_baud_rate_generator;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic sck_in;
  logic sck_run = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic wb_ack_o;
  logic [31:0] wb_dat_o;
  logic sample_tick;
  logic bit_tick;
  logic slot_valid;
  logic slot_ready = 1'b1;
  logic [7:0] slot_data;
  logic [31:0] q_reg[$];
  logic [7:0] q_slot[$];
  int rdy_mode = 0;
  int error_cnt = 0;
  int checked = 0;
  int n;

  always #5 ref_clk = ~ref_clk;

  ubrg_top ubrg_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .sck_in(sck_in),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .sample_tick(sample_tick), .bit_tick(bit_tick), .slot_valid(slot_valid),
    .slot_ready(slot_ready), .slot_data(slot_data));
  ubrg_far_end ubrg_far_end_i (.ref_clk(ref_clk), .run(sck_run), .sck(sck_in));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic ran_out;
    error_cnt++;
    $display("[ERR] t=%0t wait ran out got=%h exp=%h", $time, 1'b0, 1'b1);
    close_out();
  endtask

  // one classic cycle; held until ack is sampled, then released
  task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    do begin
      @(posedge ref_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (k >= 20) ran_out();
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    q_reg.push_back(exp);
    wb(a, 1'b0, 32'h00000000);
  endtask

  task automatic cfg(input logic [15:0] m, input logic [15:0] b);
    wb(ubrg_pkg::ADDR_MODE, 1'b1, {16'h0000, m});
    wb(ubrg_pkg::ADDR_BAUD, 1'b1, {16'h0000, b});
  endtask

  // edges until the chosen tick is seen, bounded
  task automatic tick(input logic sel, input int lim, output int k);
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while ((sel ? bit_tick : sample_tick) !== 1'b1 && k < lim);
    if (k >= lim) ran_out();
  endtask

  // spacing of two ticks, optionally with the functional clock stopped between
  task automatic gap(input logic sel, input int pause, input int exp);
    int k;
    tick(sel, 3000, k);
    if (pause > 0) begin
      clk_en <= 1'b0;
      repeat (pause) @(posedge ref_clk);
      clk_en <= 1'b1;
    end
    tick(sel, 3000, k);
    check(32'(k + pause), 32'(exp + pause));
  endtask

  task automatic quiet(input int len);
    int k;
    k = 0;
    repeat (len) begin
      @(posedge ref_clk);
      if (sample_tick === 1'b1 || bit_tick === 1'b1) k++;
    end
    check(32'(k), 32'h00000000);
  endtask

  // slot word: msb flag, parity slot, last, first, position
  task automatic frame(input int ft, input int db, input logic par, input logic msb);
    for (int p = 0; p < ft; p++)
      q_slot.push_back({msb, par && p == db + 1, p == ft - 1, p == 0, 4'(p)});
  endtask

  task automatic qwait(input int left);
    int k;
    k = 0;
    while (q_slot.size() > left && k < 3000) begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= 3000) ran_out();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // consumer: always ready, random, or stalled
  always @(posedge ref_clk) begin
    slot_ready <= (rdy_mode == 0) ? 1'b1 : (rdy_mode == 1) ? 1'($urandom % 2) : 1'b0;
  end

  // result watcher: oldest note against each answer or accepted word
  always @(posedge ref_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && q_reg.size() > 0) check(wb_dat_o, q_reg.pop_front());
    if (slot_valid === 1'b1 && slot_ready === 1'b1 && q_slot.size() > 0)
      check({24'h000000, slot_data}, {24'h000000, q_slot.pop_front()});
  end

  initial begin
    #900000;
    ran_out();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(71));
    repeat (12) @(posedge ref_clk);
    check({wb_ack_o, sample_tick, bit_tick, slot_valid}, 32'h00000000);
    rst_n <= 1'b1;
    rd(ubrg_pkg::ADDR_MODE, 32'h00000000);
    rd(ubrg_pkg::ADDR_BAUD, 32'h00000000);
    // reset mode: 5 data bits, even parity, one stop, so 8 ticks and 16 half bits
    rd(ubrg_pkg::ADDR_STATUS, 32'h00001080);
    rd(8'h0C, 32'h00000000);
    quiet(100);
    wb(8'h0C, 1'b1, 32'h0000FFFF);
    rd(ubrg_pkg::ADDR_MODE, 32'h00000000);
    wb(ubrg_pkg::ADDR_MODE, 1'b1, 32'hFFFFFFFF);
    rd(ubrg_pkg::ADDR_MODE, {16'h0000, ubrg_pkg::MODE_MASK});
    $display("test registers done");
    // every parity, stop and length code in both modes, read back as frame length
    for (int y = 0; y < 2; y++)
      for (int p = 0; p < 5; p++)
        for (int s = 0; s < 3; s++) begin
          int db;
          int bits;
          int hb;
          db = (s == 2) ? 9 : 5 + p % 4;
          bits = 1 + db + (p < 4);
          hb = 2 * bits + ((s == 2) ? 4 : (s == 1 && y == 0) ? 3 : 2);
          wb(ubrg_pkg::ADDR_MODE, 1'b1, 32'(y << 2 | (p % 4) << 4 | (s == 2) << 6 | p << 8 | s << 11));
          rd(ubrg_pkg::ADDR_STATUS, 32'((hb << 8) | (((hb + 1) / 2) << 4)));
        end
    $display("test frame formats done");
    n = 1 + $urandom % 6;
    cfg(16'h0400, 16'(n));
    gap(1'b0, 0, n);
    gap(1'b1, 0, 16 * n);
    cfg(16'h0408, 16'h0002);
    gap(1'b1, 0, 16);
    cfg(16'h0400, 16'h0001);
    gap(1'b0, 0, 1);
    cfg(16'h0401, 16'h0003);
    gap(1'b0, 0, 8 * 3);
    cfg(16'h0402, 16'h0001);
    gap(1'b0, 0, 1);
    $display("test async rates done");
    cfg(16'h0408, 16'h0002);
    gap(1'b1, 20, 16);
    clk_en <= 1'b0;
    wb(ubrg_pkg::ADDR_BAUD, 1'b1, 32'h00000003);
    rd(ubrg_pkg::ADDR_BAUD, 32'h00000003);
    quiet(30);
    clk_en <= 1'b1;
    gap(1'b0, 0, 3);
    wb(ubrg_pkg::ADDR_BAUD, 1'b1, 32'h000000C8);
    repeat (10) @(posedge ref_clk);
    wb(ubrg_pkg::ADDR_BAUD, 1'b1, 32'h00000002);
    tick(1'b0, 5, n);
    gap(1'b0, 0, 2);
    $display("test gating and reload done");
    cfg(16'h0404, 16'h0005);
    gap(1'b1, 0, 5);
    gap(1'b0, 0, 5);
    sck_run <= 1'b1;
    cfg(16'h0407, 16'h0007);
    gap(1'b1, 0, 10);
    sck_run <= 1'b0;
    $display("test sync rates done");
    // slot stream with a random and then stalled consumer
    wb(ubrg_pkg::ADDR_BAUD, 1'b1, 32'h00000000);
    repeat (4) @(posedge ref_clk);
    wb(ubrg_pkg::ADDR_MODE, 1'b1, 32'h00000438);
    frame(10, 8, 1'b0, 1'b0);
    frame(10, 8, 1'b0, 1'b0);
    frame(10, 8, 1'b0, 1'b0);
    rdy_mode = 1;
    wb(ubrg_pkg::ADDR_BAUD, 1'b1, 32'h00000001);
    qwait(2);
    rdy_mode = 2;
    repeat (60) @(posedge ref_clk);
    quiet(40);
    rd(ubrg_pkg::ADDR_STATUS, 32'h000014A3);
    rdy_mode = 1;
    qwait(0);
    // words made after the last note must drain, or one leaks into the next format
    rdy_mode = 0;
    wb(ubrg_pkg::ADDR_BAUD, 1'b1, 32'h00000000);
    repeat (4) @(posedge ref_clk);
    wb(ubrg_pkg::ADDR_MODE, 1'b1, 32'h00001088);
    frame(9, 5, 1'b1, 1'b1);
    frame(9, 5, 1'b1, 1'b1);
    rdy_mode = 1;
    wb(ubrg_pkg::ADDR_BAUD, 1'b1, 32'h00000001);
    qwait(0);
    rdy_mode = 0;
    $display("test slot stream done");
    close_out();
  end
endmodule
